/* File: hdl/gpm_general_pin.sv */
// General pin 0 mode multiplexer with its host registers
`timescale 1ns/10ps
`default_nettype none

module gpm_general_pin (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	// Host register access
	input  wire gpm_pkg::gpm_host_req_s     hostReq,
	output logic [7:0]                      hostRdData,
	output logic                            hostRdValid,
	// Pin
	input  wire logic                       pinIn,
	output logic                            pinOut,
	output logic                            pinOe_b,
	// Selected host register bit
	output logic [gpm_pkg::ABS_W-1:0]       selAddr,
	output logic [2:0]                      selBitPos,
	input  wire logic                       selBitIn,
	// Controlled device function
	output logic                            ctrlValue,
	output logic                            ctrlUpdate
);

	gpm_pkg::gpm_state_s st;
	gpm_pkg::gpm_state_s stNext;

	// Mode code to pin role
	function automatic gpm_pkg::gpm_role_e decodeRole(input logic [gpm_pkg::MODE_W-1:0] mode);
		case (mode)
			gpm_pkg::MODE_IN:   decodeRole = gpm_pkg::ROLE_IN;
			gpm_pkg::MODE_OUT:  decodeRole = gpm_pkg::ROLE_OUT;
			gpm_pkg::MODE_CTRL: decodeRole = gpm_pkg::ROLE_CTRL;
			gpm_pkg::MODE_STAT: decodeRole = gpm_pkg::ROLE_STAT;
			default:            decodeRole = gpm_pkg::ROLE_SAFE;
		endcase
	endfunction : decodeRole

	// Page-relative offset to absolute map address
	function automatic logic [gpm_pkg::ABS_W-1:0] absAddr(input logic [7:0] page,
		input logic [gpm_pkg::OFS_W-1:0] ofs);
		absAddr = {page[gpm_pkg::PAGE_W-1:0], ofs};
	endfunction : absAddr

	logic [gpm_pkg::ABS_W-1:0] reqAbs;
	logic                      isPageSel;
	logic                      wrCfg;

	// Address decode of the current request
	assign reqAbs    = absAddr(st.pageSel, hostReq.addr);
	assign isPageSel = (hostReq.addr == gpm_pkg::OFS_PAGE_SEL);
	assign wrCfg     = hostReq.wr && !isPageSel && (reqAbs == gpm_pkg::ADDR_CFG);

	// Next state
	always_comb begin
		stNext = st;
		stNext.ctrlUpd = 1'b0;
		stNext.rdValid = 1'b0;

		// Register writes, reserved bits masked off except in page select, which keeps all 8 bits
		if (hostReq.wr) begin
			if (isPageSel) begin
				stNext.pageSel = hostReq.wdata;
			end else begin
				case (reqAbs)
					gpm_pkg::ADDR_SEL_HI: stNext.sel[15:8] = hostReq.wdata & gpm_pkg::MASK_SEL_HI;
					gpm_pkg::ADDR_SEL_LO: stNext.sel[7:0] = hostReq.wdata & gpm_pkg::MASK_SEL_LO;
					gpm_pkg::ADDR_CFG:    stNext.cfg = hostReq.wdata & gpm_pkg::MASK_CFG;
					gpm_pkg::ADDR_OUT:    stNext.outVal = hostReq.wdata & gpm_pkg::MASK_OUT;
					default:              stNext.outVal = st.outVal;
				endcase
			end
		end

		// Role changes only with the mode register
		stNext.role = decodeRole(stNext.cfg[gpm_pkg::MODE_LSB +: gpm_pkg::MODE_W]);

		// Register reads, unmapped reads give zero
		if (hostReq.rd) begin
			stNext.rdValid = 1'b1;
			if (isPageSel) begin
				stNext.rdData = st.pageSel;
			end else begin
				case (reqAbs)
					gpm_pkg::ADDR_SEL_HI: stNext.rdData = st.sel[15:8];
					gpm_pkg::ADDR_SEL_LO: stNext.rdData = st.sel[7:0];
					gpm_pkg::ADDR_CFG:    stNext.rdData = st.cfg;
					gpm_pkg::ADDR_OUT:    stNext.rdData = st.outVal;
					gpm_pkg::ADDR_INSTAT: stNext.rdData = {7'h00, st.inStat};
					default:              stNext.rdData = gpm_pkg::RD_ZERO;
				endcase
			end
		end

		// Pin behaviour per role
		stNext.prevPin = pinIn;
		stNext.prevBit = selBitIn;
		case (stNext.role)
			gpm_pkg::ROLE_IN: begin
				stNext.pinOe_b = 1'b1;
				stNext.pinOut  = 1'b0;
				stNext.inStat  = pinIn;
			end
			gpm_pkg::ROLE_OUT: begin
				stNext.pinOe_b = 1'b0;
				stNext.pinOut  = stNext.outVal[0];
			end
			gpm_pkg::ROLE_CTRL: begin
				stNext.pinOe_b = 1'b1;
				stNext.pinOut  = 1'b0;
				// Apply on entry and on any change of pin or host bit
				if ((st.role != gpm_pkg::ROLE_CTRL) || (pinIn != st.prevPin) || (selBitIn != st.prevBit)) begin
					stNext.ctrlUpd = 1'b1;
					stNext.ctrlVal = pinIn | selBitIn;
				end
			end
			gpm_pkg::ROLE_STAT: begin
				stNext.pinOe_b = 1'b0;
				stNext.pinOut  = selBitIn;
			end
			default: begin
				stNext.pinOe_b = 1'b1;
				stNext.pinOut  = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st.sel     <= gpm_pkg::RST_SEL;
			st.cfg     <= gpm_pkg::RST_CFG;
			st.outVal  <= gpm_pkg::RST_OUT;
			st.inStat  <= 1'b0;
			st.pageSel <= gpm_pkg::RST_PAGE;
			st.role    <= gpm_pkg::ROLE_IN;
			st.pinOut  <= 1'b0;
			st.pinOe_b <= 1'b1;
			st.ctrlVal <= 1'b0;
			st.ctrlUpd <= 1'b0;
			st.prevPin <= 1'b0;
			st.prevBit <= 1'b0;
			st.rdData  <= gpm_pkg::RD_ZERO;
			st.rdValid <= 1'b0;
		end else begin
			st <= stNext;
		end
	end

	// Outputs straight from the state register
	assign hostRdData  = st.rdData;
	assign hostRdValid = st.rdValid;
	assign pinOut      = st.pinOut;
	assign pinOe_b     = st.pinOe_b;
	assign selAddr     = {st.sel[gpm_pkg::SEL_PAGE_LSB +: gpm_pkg::PAGE_W],
		st.sel[gpm_pkg::SEL_OFS_LSB +: gpm_pkg::OFS_W]};
	assign selBitPos   = st.sel[gpm_pkg::SEL_BIT_LSB +: 3];
	assign ctrlValue   = st.ctrlVal;
	assign ctrlUpdate  = st.ctrlUpd;

	// Checks

	sequence seq_cfg_write;
		wrCfg;
	endsequence

	sequence seq_sel_hi_write;
		hostReq.wr && !isPageSel && (reqAbs == gpm_pkg::ADDR_SEL_HI);
	endsequence

	sequence seq_sel_lo_write;
		hostReq.wr && !isPageSel && (reqAbs == gpm_pkg::ADDR_SEL_LO);
	endsequence

	a_mode_takes_write: assert property (@(posedge clk) disable iff (!rst_b)
		seq_cfg_write |=> (st.cfg[2:0] == $past(hostReq.wdata[2:0])) && (st.role == decodeRole($past(hostReq.wdata[2:0]))))
		else $error("mode not taken from write");

	a_mode_holds_idle: assert property (@(posedge clk) disable iff (!rst_b)
		!wrCfg |=> $stable(st.cfg) && $stable(st.role))
		else $error("mode changed without write");

	a_sel_hi_fields: assert property (@(posedge clk) disable iff (!rst_b)
		seq_sel_hi_write |=> (selBitPos == $past(hostReq.wdata[6:4])) && (selAddr[10:7] == $past(hostReq.wdata[3:0])))
		else $error("bit or page field wrong");

	a_sel_lo_offset: assert property (@(posedge clk) disable iff (!rst_b)
		seq_sel_lo_write |=> (selAddr[6:0] == $past(hostReq.wdata[6:0])))
		else $error("offset field wrong");

	a_input_status: assert property (@(posedge clk) disable iff (!rst_b)
		(st.role == gpm_pkg::ROLE_IN) && !wrCfg |=> pinOe_b && (st.inStat == $past(pinIn)))
		else $error("input status not following pin");

	a_output_drive: assert property (@(posedge clk) disable iff (!rst_b)
		(st.role == gpm_pkg::ROLE_OUT) |-> !pinOe_b && (pinOut == st.outVal[0]))
		else $error("output mode not driving register bit");

	a_ctrl_change: assert property (@(posedge clk) disable iff (!rst_b)
		(st.role == gpm_pkg::ROLE_CTRL) && !wrCfg && ((pinIn != st.prevPin) || (selBitIn != st.prevBit))
		|=> ctrlUpdate && (ctrlValue == ($past(pinIn) | $past(selBitIn))))
		else $error("control change not applied");

	a_ctrl_quiet: assert property (@(posedge clk) disable iff (!rst_b)
		(st.role != gpm_pkg::ROLE_CTRL) |-> !ctrlUpdate)
		else $error("control update outside control mode");

	a_status_mirror: assert property (@(posedge clk) disable iff (!rst_b)
		(st.role == gpm_pkg::ROLE_STAT) && !wrCfg |=> !pinOe_b && (pinOut == $past(selBitIn)))
		else $error("status mirror wrong");

	a_reserved_safe: assert property (@(posedge clk) disable iff (!rst_b)
		seq_cfg_write ##0 (hostReq.wdata[2] == 1'b1) |=> pinOe_b [*2])
		else $error("reserved mode drives pin");

	a_page_readback: assert property (@(posedge clk) disable iff (!rst_b)
		hostReq.rd && !hostReq.wr && isPageSel |=> hostRdValid && (hostRdData == $past(st.pageSel)))
		else $error("page select readback wrong");

endmodule : gpm_general_pin

`default_nettype wire

/* File: hdl/gpm_pkg.sv */
// Constants, types and carriers for the general pin mode multiplexer
// What this block does
// - Selector bits 14:12 give the bit position inside the chosen host byte.
// - Selector bits 11:8 give the page of the chosen host bit.
// - Selector bits 6:0 give the byte offset inside the chosen page.
// - Selector only matters in control or status mode, ignored otherwise.
// - Mode comes from bits 2:0 of the mode configuration register.
// - Mode 000: pin is input, level shown in bit 0 at 0x140.
// - Mode 001: pin is driven with bit 0 of register 0x0EF.
// - Mode 010: on any change, OR of pin and host bit is applied.
// - Mode 011: pin continuously mirrors the selected host register bit.
// - Old mode stays in force until the mode register is written.
// - Host map is 128-byte pages, page chosen by a page select register.
package gpm_pkg;

	// Widths of the host register map
	localparam int PAGE_W = 4;
	localparam int OFS_W  = 7;
	localparam int ABS_W  = PAGE_W + OFS_W;

	// Absolute addresses of the registers held here
	localparam logic [ABS_W-1:0] ADDR_SEL_HI = 11'h0e0;
	localparam logic [ABS_W-1:0] ADDR_SEL_LO = 11'h0e1;
	localparam logic [ABS_W-1:0] ADDR_CFG    = 11'h0e2;
	localparam logic [ABS_W-1:0] ADDR_OUT    = 11'h0ef;
	localparam logic [ABS_W-1:0] ADDR_INSTAT = 11'h140;
	// Page select sits at this offset in every page
	localparam logic [OFS_W-1:0] OFS_PAGE_SEL = 7'h7f;

	// Field positions
	localparam int SEL_BIT_LSB  = 12;
	localparam int SEL_PAGE_LSB = 8;
	localparam int SEL_OFS_LSB  = 0;
	localparam int MODE_LSB     = 0;
	localparam int MODE_W       = 3;

	// Writable masks, reserved bits stay zero
	localparam logic [7:0] MASK_SEL_HI = 8'h7f;
	localparam logic [7:0] MASK_SEL_LO = 8'h7f;
	localparam logic [7:0] MASK_CFG    = 8'h07;
	localparam logic [7:0] MASK_OUT    = 8'h01;

	// Reset values
	localparam logic [15:0] RST_SEL  = 16'h0000;
	localparam logic [7:0]  RST_CFG  = 8'h00;
	localparam logic [7:0]  RST_OUT  = 8'h00;
	localparam logic [7:0]  RST_PAGE = 8'h00;
	localparam logic [7:0]  RD_ZERO  = 8'h00;

	// Mode codes
	localparam logic [MODE_W-1:0] MODE_IN   = 3'h0;
	localparam logic [MODE_W-1:0] MODE_OUT  = 3'h1;
	localparam logic [MODE_W-1:0] MODE_CTRL = 3'h2;
	localparam logic [MODE_W-1:0] MODE_STAT = 3'h3;

	// Decoded pin role, one-hot
	typedef enum logic [4:0] {
		ROLE_IN   = 5'h01,
		ROLE_OUT  = 5'h02,
		ROLE_CTRL = 5'h04,
		ROLE_STAT = 5'h08,
		ROLE_SAFE = 5'h10
	} gpm_role_e;

	// Host register access request
	typedef struct packed {
		logic             wr;
		logic             rd;
		logic [OFS_W-1:0] addr;
		logic [7:0]       wdata;
	} gpm_host_req_s;

	// Whole state of the block
	typedef struct packed {
		logic [15:0] sel;
		logic [7:0]  cfg;
		logic [7:0]  outVal;
		logic        inStat;
		logic [7:0]  pageSel;
		gpm_role_e   role;
		logic        pinOut;
		logic        pinOe_b;
		logic        ctrlVal;
		logic        ctrlUpd;
		logic        prevPin;
		logic        prevBit;
		logic [7:0]  rdData;
		logic        rdValid;
	} gpm_state_s;

endpackage : gpm_pkg

/* File: tb/gpm_pin_partner.sv */
// Pin wire model: external circuitry sharing general pin 0
`timescale 1ns/10ps
`default_nettype none

module gpm_pin_partner (
	// Clock
	input  wire logic clk,
	// Block side of the wire
	input  wire logic pinOut,
	input  wire logic pinOe_b,
	// Far side driver
	input  wire logic extDrive,
	input  wire logic extLevel,
	// Resolved wire
	output logic      pinLevel
);
	logic floatVal = 1'b0;

	// Undriven wire wanders each cycle, no pull resistor
	always @(posedge clk) floatVal <= ~floatVal;

	// Block drives when enabled low, else the far side or nothing
	always_comb begin
		pinLevel = !pinOe_b ? pinOut : (extDrive ? extLevel : floatVal);
	end
endmodule : gpm_pin_partner

`default_nettype wire

/* File: tb/tb_general_pin_mode_mux.sv */
// Self-checking bench for the general pin 0 mode multiplexer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_general_pin_mode_mux;
	typedef struct packed { logic w; logic [6:0] a; logic [7:0] d; } gpm_row_s;

	logic                    clk = 1'b0;
	logic                    rst_b;
	gpm_pkg::gpm_host_req_s  hostReq;
	logic [7:0]              hostRdData;
	logic                    hostRdValid;
	logic                    pinLevel;
	logic                    pinOut;
	logic                    pinOe_b;
	logic [gpm_pkg::ABS_W-1:0] selAddr;
	logic [2:0]              selBitPos;
	logic                    selBitIn;
	logic                    ctrlValue;
	logic                    ctrlUpdate;
	logic                    extDrive;
	logic                    extLevel;
	int                      mismatches = 0;
	int                      nChecks = 0;
	int                      cycles = 0;
	// Page 1 register cases: writes, then reads with expected data
	gpm_row_s rows [13] = '{'{1'b1, 7'h7f, 8'h01}, '{1'b0, 7'h60, 8'h00}, '{1'b0, 7'h61, 8'h00},
		'{1'b0, 7'h62, 8'h00}, '{1'b0, 7'h6f, 8'h00}, '{1'b1, 7'h60, 8'hff}, '{1'b0, 7'h60, 8'h7f},
		'{1'b1, 7'h61, 8'hff}, '{1'b0, 7'h61, 8'h7f}, '{1'b1, 7'h6f, 8'hff}, '{1'b0, 7'h6f, 8'h01},
		'{1'b0, 7'h00, 8'h00}, '{1'b0, 7'h7f, 8'h01}};

	// Clock at 40 MHz
	always #12.5 clk = ~clk;

	gpm_general_pin uut (.clk(clk), .rst_b(rst_b), .hostReq(hostReq), .hostRdData(hostRdData),
		.hostRdValid(hostRdValid), .pinIn(pinLevel), .pinOut(pinOut), .pinOe_b(pinOe_b),
		.selAddr(selAddr), .selBitPos(selBitPos), .selBitIn(selBitIn), .ctrlValue(ctrlValue),
		.ctrlUpdate(ctrlUpdate));

	gpm_pin_partner far (.clk(clk), .pinOut(pinOut), .pinOe_b(pinOe_b), .extDrive(extDrive),
		.extLevel(extLevel), .pinLevel(pinLevel));

	// Counts, verdict and end of run
	task automatic printVerdict();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : printVerdict

	// One host access; a read compares the answer one cycle later
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		hostReq <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		hostReq <= '0;
		#1;
		if (!w) `CHK(hostRdData, d)
		if (!w) `CHK(hostRdValid, 1'b1)
	endtask : acc

	// Control pulse one cycle after the change, gone the cycle after
	task automatic waitUpd(input logic v);
		@(posedge clk) #1;
		`CHK(ctrlUpdate, 1'b1)
		`CHK(ctrlValue, v)
		@(posedge clk) #1;
		`CHK(ctrlUpdate, 1'b0)
	endtask : waitUpd

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			printVerdict();
		end
	end

	// Main sequence
	initial begin
		hostReq = '0;
		selBitIn = 1'b0;
		extDrive = 1'b1;
		extLevel = 1'b0;
		rst_b = 1'b0;
		repeat (10) @(posedge clk);
		`CHK(pinOe_b, 1'b1)
		`CHK(selAddr, 11'h000)
		rst_b <= 1'b1;
		$display("done: reset");
		foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d);
		$display("done: register rows");
		// Selector set while in input mode
		acc(1'b1, 7'h60, 8'h5a);
		acc(1'b1, 7'h61, 8'h33);
		`CHK(selAddr, 11'h533)
		`CHK(selBitPos, 3'h5)
		`CHK(pinOe_b, 1'b1)
		$display("done: selector");
		@(posedge clk);
		extDrive <= 1'b0;
		acc(1'b1, 7'h62, 8'h01);
		`CHK(pinOe_b, 1'b0)
		`CHK(pinLevel, 1'b1)
		acc(1'b1, 7'h6f, 8'h00);
		`CHK(pinLevel, 1'b0)
		$display("done: output mode");
		acc(1'b1, 7'h62, 8'h03);
		@(posedge clk);
		selBitIn <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(pinLevel, 1'b1)
		acc(1'b1, 7'h60, 8'h00);
		`CHK(pinOe_b, 1'b0)
		$display("done: status mode");
		// Far side matches the mirrored level, so entry is the only event
		@(posedge clk);
		extDrive <= 1'b1;
		extLevel <= 1'b1;
		acc(1'b1, 7'h62, 8'h02);
		`CHK(ctrlUpdate, 1'b1)
		`CHK(ctrlValue, 1'b1)
		@(posedge clk);
		selBitIn <= 1'b0;
		waitUpd(1'b1);
		@(posedge clk);
		extLevel <= 1'b0;
		waitUpd(1'b0);
		@(posedge clk);
		extLevel <= 1'b1;
		waitUpd(1'b1);
		`CHK(pinOe_b, 1'b1)
		$display("done: control mode");
		acc(1'b1, 7'h62, 8'h00);
		acc(1'b1, 7'h7f, 8'h02);
		acc(1'b0, 7'h40, 8'h01);
		// Pin and host bit both move, no control pulse outside control mode
		@(posedge clk);
		extLevel <= 1'b0;
		selBitIn <= 1'b1;
		@(posedge clk) #1;
		`CHK(ctrlUpdate, 1'b0)
		acc(1'b0, 7'h40, 8'h00);
		$display("done: input mode");
		// Reserved code entered from a driving mode must release the pin
		acc(1'b1, 7'h7f, 8'h01);
		acc(1'b1, 7'h6f, 8'h01);
		acc(1'b1, 7'h62, 8'h01);
		`CHK(pinOe_b, 1'b0)
		acc(1'b1, 7'h62, 8'hfc);
		`CHK(pinOe_b, 1'b1)
		`CHK(pinOut, 1'b0)
		acc(1'b0, 7'h62, 8'h04);
		$display("done: reserved mode");
		// Reset in mid-run brings every register back to its reset value
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk) #1;
		`CHK(selAddr, 11'h000)
		`CHK(pinOe_b, 1'b1)
		`CHK(hostRdValid, 1'b0)
		@(posedge clk);
		rst_b <= 1'b1;
		acc(1'b0, 7'h7f, 8'h00);
		acc(1'b1, 7'h7f, 8'h01);
		acc(1'b0, 7'h62, 8'h00);
		$display("done: reset in mid-run");
		printVerdict();
	end
endmodule : tb_general_pin_mode_mux

`default_nettype wire
